// file: tone_detector_pkg.sv
// Shared constants and helpers for the tone detector bank.
// Assumes word-indexed locations; the APB byte address is four times the index.
package tone_detector_pkg;

   // ****************************************
   // Location indices
   // ****************************************
   localparam int unsigned ADDR_W     = 11;
   localparam logic [8:0]  IDX_FLAGS  = 9'h000;
   localparam logic [8:0]  IDX_DTHR   = 9'h003;
   localparam logic [8:0]  IDX_LEV    = 9'h026;
   localparam logic [8:0]  IDX_BON    = 9'h051;
   localparam logic [8:0]  IDX_BOFF   = 9'h052;
   localparam logic [8:0]  IDX_EQAVG  = 9'h092;
   localparam logic [8:0]  IDX_COEF   = 9'h145;
   localparam logic [8:0]  IDX_BQA    = 9'h155;
   localparam logic [8:0]  IDX_BQB    = 9'h15F;
   localparam logic [8:0]  IDX_MODE   = 9'h1A0;
   localparam logic [8:0]  IDX_MISC   = 9'h1A1;
   localparam logic [8:0]  IDX_TSTAT  = 9'h1A2;
   localparam logic [8:0]  IDX_EQLIM  = 9'h1A3;
   localparam logic [8:0]  N_DTD      = 9'h010;
   localparam logic [8:0]  N_BQ_ALL   = 9'h014;

   // ****************************************
   // Modes, bit positions, defaults
   // ****************************************
   localparam logic [6:0]  MODE_STANDBY = 7'h00;
   localparam logic [6:0]  MODE_DETECT  = 7'h02;
   localparam int unsigned EYE_BIT      = 4;
   localparam int unsigned TS_A_BIT     = 15;
   localparam int unsigned TS_B_BIT     = 14;
   localparam int unsigned TS_CHAIN_BIT = 13;
   localparam int unsigned TS_SQB_BIT   = 5;
   localparam logic [15:0] DTHR_DEF     = 16'h0814;  // -24 dBm
   localparam logic [15:0] BON_DEF      = 16'h0247;  // -35 dBm
   localparam logic [15:0] BOFF_DEF     = 16'h0104;  // -42 dBm
   localparam logic [15:0] EQLIM_DEF    = 16'h1000;
   localparam logic [15:0] PART_ID_DEF  = 16'h5A3C;  // Arbitrary value
   localparam int unsigned LEV_SHIFT    = 5;
   localparam int unsigned EQ_SHIFT     = 4;
   localparam int unsigned IN_SHIFT     = 4;
   localparam int unsigned DAMP_SHIFT   = 7;
   localparam int unsigned Q_SHIFT      = 14;
   localparam int unsigned SQ_SHIFT     = 15;

   // Band filter defaults: A then B, each b2 b1 a3 a2 a1 B2 B1 A3 A2 A1
   localparam logic [0:19][15:0] BQ_DEF = '{
      16'hC774, 16'h7601, 16'h0716, 16'hF5FB, 16'h0716,
      16'hC63E, 16'h6FE1, 16'hF8EA, 16'h0000, 16'h0716,
      16'hC148, 16'h7A66, 16'hFF5C, 16'h0000, 16'h00A4,
      16'hC7CD, 16'h7438, 16'h01AA, 16'hFEBC, 16'h01AA};

   // Symmetric clamp keeps the magnitude of the result representable
   function automatic logic [15:0] sat16(input logic signed [35:0] v);
      if (v > 36'sd32767) return 16'h7FFF;
      if (v < -36'sd32767) return 16'h8001;
      return v[15:0];
   endfunction : sat16

   function automatic logic [15:0] absv(input logic [15:0] v);
      return v[15] ? 16'(-v) : v;
   endfunction : absv

   // Leaky average: old moves 1/2^sh of the way toward smp
   function automatic logic [15:0] leak(input logic [15:0] old, input logic [15:0] smp,
                                        input int unsigned sh);
      logic signed [16:0] d;
      d = $signed({1'b0, smp}) - $signed({1'b0, old});
      return old + 16'(d >>> sh);
   endfunction : leak

endpackage : tone_detector_pkg

// file: band_detector.sv
// Two cascaded biquad sections, band power estimate and hysteresis flag.
// Assumes x_valid pulses once per received sample and thresholds are stable.
`timescale 1ns/1ns
module band_detector
   import tone_detector_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              run,
   input  wire logic              x_valid,
   input  wire logic [15:0]       x,
   input  wire logic [0:9][15:0]  coef,
   input  wire logic [15:0]       on_point,
   input  wire logic [15:0]       off_point,
   output logic      [15:0]       y,
   output logic                   flag
);

   typedef struct packed {
      logic [15:0] x1, x2, y1, y2, v1, v2, pwr;
      logic        hit;
   } bd_s;

   bd_s q, n;

   // One section: y = 2(a1 x + a2 x1 + a3 x2) + 2 b1 y1 + 2 b2 y2, Q15
   function automatic logic [15:0] sect(input logic [0:4][15:0] c,
                                        input logic [15:0] x0, x1, x2, y1, y2);
      logic signed [35:0] acc;
      acc = 36'($signed(c[4]) * $signed(x0)) + 36'($signed(c[3]) * $signed(x1))
          + 36'($signed(c[2]) * $signed(x2)) + 36'($signed(c[1]) * $signed(y1))
          + 36'($signed(c[0]) * $signed(y2));
      return sat16(acc >>> Q_SHIFT);
   endfunction : sect

   // ****************************************
   // Filter, power and hysteresis
   // ****************************************
   always_comb begin
      logic [15:0] s1;
      logic [15:0] s2;
      s1 = sect(coef[0:4], x, q.x1, q.x2, q.y1, q.y2);
      s2 = sect(coef[5:9], s1, q.y1, q.y2, q.v1, q.v2);
      n  = q;
      if (!run) begin
         n = '0;  // Leaving detect mode flushes history
      end else if (x_valid) begin
         n.x2  = q.x1;
         n.x1  = x;
         n.y2  = q.y1;
         n.y1  = s1;
         n.v2  = q.v1;
         n.v1  = s2;
         n.pwr = leak(q.pwr, absv(s2), LEV_SHIFT);
         // Equal to a threshold holds the flag, giving a dead band
         if (n.pwr > on_point) n.hit = 1'b1;
         else if (n.pwr < off_point) n.hit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) q <= '0;
      else q <= n;
   end

   assign y    = q.v1;
   assign flag = q.hit;

   // Judged one cycle after a sample, against the thresholds that sample saw;
   // a threshold write between samples must not trip these
   a_band_on: assert property (@(posedge pclk) disable iff (!presetn)
      run && x_valid ##1 q.pwr > $past(on_point) |-> q.hit)
      else $error("band flag low above on point");
   a_band_off: assert property (@(posedge pclk) disable iff (!presetn)
      run && x_valid ##1 q.pwr < $past(off_point) && q.pwr <= $past(on_point) |-> !q.hit)
      else $error("band flag high below off point");

endmodule : band_detector

// file: tone_detector_bank.sv
// Tone detection unit: sixteen discrete detectors, two band detectors,
// eye quality monitor, all behind an APB slave.
// Assumes rx_valid pulses once per 9600 Hz sample and err inputs are
// valid with err_valid while V.22 reception runs.
//
// Operation
// - Ten biquad coefficients each for A, B
// - Sixteen writable discrete detector coefficient words
// - Running mean square error during V.22
// - Eye flag set above limit, else clear
// - Band flag clears below off point
// - Band flag sets above on point
// - Detect mode reloads off point default
// - Detect mode reloads on point default
// - Thresholds compare linearly against measured level
// - Detect mode writes each detector level word
// - Shared discrete threshold turns bits on/off
// - Detect mode reloads discrete threshold default
// - One status bit per discrete detector
// - Standby or reset writes part identifier
// - Band and discrete detectors run together
// - Band A on bit 15, B 14
// - Chain bit cascades; bypass skips squarer
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
module tone_detector_bank
   import tone_detector_pkg::*;
#(
   parameter logic [15:0] PART_ID = PART_ID_DEF  // Arbitrary value
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              rx_valid,
   input  wire logic [15:0]       rx_sample,
   input  wire logic              v22_rx_active,
   input  wire logic              err_valid,
   input  wire logic [15:0]       err_re,
   input  wire logic [15:0]       err_im,
   output logic                   eye_quality_error_flag
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [6:0]         mode;
      logic [15:0]        flags;
      logic [15:0]        dthr;
      logic [15:0]        bon;
      logic [15:0]        boff;
      logic [15:0]        eqavg;
      logic [15:0]        eqlim;
      logic               eye;
      logic               chain;
      logic               sqb;
      logic               perr;
      logic [15:0]        prdata;
      logic [15:0][15:0]  lev;
      logic [15:0][15:0]  coef;
      logic [0:19][15:0]  bq;
      logic [15:0][15:0]  s1;
      logic [15:0][15:0]  s2;
   } st_s;

   // Discrete coefficients reset to zero; software loads its tones
   localparam st_s ST_RST = '{
      mode:  MODE_STANDBY,
      flags: PART_ID,
      dthr:  DTHR_DEF,
      bon:   BON_DEF,
      boff:  BOFF_DEF,
      eqlim: EQLIM_DEF,
      bq:    BQ_DEF,
      default: '0};

   st_s q, n;

   logic [8:0]  idx;
   logic        wr;
   logic        detect;
   logic        flag_a;
   logic        flag_b;
   logic [15:0] y_b;
   logic [15:0] a_in;

   assign idx    = paddr[10:2];
   assign wr     = psel && penable && pwrite;
   assign detect = (q.mode == MODE_DETECT);

   // ****************************************
   // Address decode helpers
   // ****************************************
   function automatic logic win(input logic [8:0] i, input logic [8:0] base,
                                input logic [8:0] cnt);
      return (i >= base) && (i < 9'(base + cnt));
   endfunction : win

   function automatic logic [4:0] woff(input logic [8:0] i, input logic [8:0] base);
      return 5'(i - base);
   endfunction : woff

   function automatic logic mapped(input logic [8:0] i);
      return (i == IDX_FLAGS) || (i == IDX_DTHR) || (i == IDX_BON)
          || (i == IDX_BOFF) || (i == IDX_EQAVG) || (i == IDX_MODE)
          || (i == IDX_MISC) || (i == IDX_TSTAT) || (i == IDX_EQLIM)
          || win(i, IDX_LEV, N_DTD) || win(i, IDX_COEF, N_DTD)
          || win(i, IDX_BQA, N_BQ_ALL);
   endfunction : mapped

   // ****************************************
   // Register file, discrete detectors, eye monitor
   // ****************************************
   always_comb begin
      logic [15:0]        rd;
      logic [15:0]        s;
      logic signed [35:0] acc;
      logic [33:0]        e2;
      logic [15:0]        sqv;
      rd  = 16'h0000;
      s   = 16'h0000;
      acc = '0;
      e2  = '0;
      sqv = 16'h0000;
      n   = q;

      // Read data is captured in the setup cycle so it leaves a flop
      if (win(idx, IDX_LEV, N_DTD))        rd = q.lev[woff(idx, IDX_LEV)];
      else if (win(idx, IDX_COEF, N_DTD))  rd = q.coef[woff(idx, IDX_COEF)];
      else if (win(idx, IDX_BQA, N_BQ_ALL)) rd = q.bq[woff(idx, IDX_BQA)];
      else begin
         case (idx)
            IDX_FLAGS: rd = q.flags;
            IDX_DTHR:  rd = q.dthr;
            IDX_BON:   rd = q.bon;
            IDX_BOFF:  rd = q.boff;
            IDX_EQAVG: rd = q.eqavg;
            IDX_EQLIM: rd = q.eqlim;
            IDX_MODE:  rd = {9'h000, q.mode};
            IDX_MISC:  rd = 16'(q.eye) << EYE_BIT;
            IDX_TSTAT: begin
               rd[TS_A_BIT]     = flag_a;
               rd[TS_B_BIT]     = flag_b;
               rd[TS_CHAIN_BIT] = q.chain;
               rd[TS_SQB_BIT]   = q.sqb;
            end
            default:   rd = 16'h0000;
         endcase
      end
      if (psel && !penable) begin
         n.prdata = rd;
         n.perr   = !mapped(idx);
      end

      // Discrete detectors: damped resonators tuned by cos coefficient
      if (!detect) begin
         n.s1 = '0;
         n.s2 = '0;
      end else if (rx_valid) begin
         for (int i = 0; i < 16; i++) begin
            acc = 36'($signed(rx_sample) >>> IN_SHIFT)
                + 36'(($signed(q.coef[i]) * $signed(q.s1[i])) >>> Q_SHIFT)
                - 36'($signed(q.s2[i]))
                + 36'($signed(q.s2[i]) >>> DAMP_SHIFT);
            s = sat16(acc);
            n.s2[i]  = q.s1[i];
            n.s1[i]  = s;
            n.lev[i] = leak(q.lev[i], absv(s), LEV_SHIFT);
            // Bit i follows detector i; level equal to threshold holds
            if (n.lev[i] > q.dthr) n.flags[i] = 1'b1;
            else if (n.lev[i] < q.dthr) n.flags[i] = 1'b0;
         end
      end

      // Eye quality: mean square of decision error
      if (v22_rx_active && err_valid) begin
         e2  = 34'($signed(err_re) * $signed(err_re))
             + 34'($signed(err_im) * $signed(err_im));
         sqv = (e2[33:SQ_SHIFT] > 19'h0FFFF) ? 16'hFFFF : e2[30:15];
         n.eqavg = leak(q.eqavg, sqv, EQ_SHIFT);
      end

      // Host writes land at the access edge and win over sample updates
      if (wr) begin
         if (win(idx, IDX_COEF, N_DTD)) begin
            n.coef[woff(idx, IDX_COEF)] = pwdata[15:0];
         end
         if (win(idx, IDX_BQA, N_BQ_ALL)) begin
            n.bq[woff(idx, IDX_BQA)] = pwdata[15:0];
         end
         case (idx)
            IDX_DTHR:  n.dthr  = pwdata[15:0];
            IDX_BON:   n.bon   = pwdata[15:0];
            IDX_BOFF:  n.boff  = pwdata[15:0];
            IDX_EQLIM: n.eqlim = pwdata[15:0];
            IDX_TSTAT: begin
               n.chain = pwdata[TS_CHAIN_BIT];
               n.sqb   = pwdata[TS_SQB_BIT];
            end
            IDX_MODE: begin
               n.mode = pwdata[6:0];
               // Entering detect restores all thresholds, so the host
               // must write its own values afterwards
               if (pwdata[6:0] == MODE_DETECT) begin
                  n.dthr = DTHR_DEF;
                  n.bon  = BON_DEF;
                  n.boff = BOFF_DEF;
               end
               if (pwdata[6:0] == MODE_STANDBY) begin
                  n.flags = PART_ID;
               end
            end
            default: ;
         endcase
      end

      n.eye = (n.eqavg > n.eqlim);
   end

   // Reset also loads the part identifier into the status word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) q <= ST_RST;
      else q <= n;
   end

   // ****************************************
   // Band detectors
   // ****************************************
   // Chained: B output, squared unless bypassed, drives A
   always_comb begin
      if (!q.chain) a_in = rx_sample;
      else if (q.sqb) a_in = y_b;
      else a_in = sat16(36'($signed(y_b) * $signed(y_b)) >>> SQ_SHIFT);
   end

   band_detector u_band_a (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (detect),
      .x_valid   (rx_valid),
      .x         (a_in),
      .coef      (q.bq[0:9]),
      .on_point  (q.bon),
      .off_point (q.boff),
      .y         (),
      .flag      (flag_a)
   );

   band_detector u_band_b (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (detect),
      .x_valid   (rx_valid),
      .x         (rx_sample),
      .coef      (q.bq[10:19]),
      .on_point  (q.bon),
      .off_point (q.boff),
      .y         (y_b),
      .flag      (flag_b)
   );

   // ****************************************
   // Bus outputs
   // ****************************************
   // Zero wait states: every access completes in its first access cycle
   assign pready  = psel && penable;
   assign pslverr = psel && penable && q.perr;
   assign prdata  = {16'h0000, q.prdata};
   assign eye_quality_error_flag = q.eye;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_mode_wr(logic [6:0] v);
      wr && idx == IDX_MODE && pwdata[6:0] == v;
   endsequence

   sequence s_quiet_sample;
      detect && rx_valid && !wr;
   endsequence

   a_dthr_reload: assert property (s_mode_wr(MODE_DETECT) |=> q.dthr == DTHR_DEF)
      else $error("discrete threshold not reloaded");
   a_bon_reload: assert property (s_mode_wr(MODE_DETECT) |=> q.bon == BON_DEF)
      else $error("on point not reloaded");
   a_boff_reload: assert property (s_mode_wr(MODE_DETECT) |=> q.boff == BOFF_DEF)
      else $error("off point not reloaded");
   a_standby_id: assert property (s_mode_wr(MODE_STANDBY) |=> q.flags == PART_ID)
      else $error("part identifier not written");
   a_eye_flag: assert property (eye_quality_error_flag == (q.eqavg > q.eqlim))
      else $error("eye flag disagrees with average");
   a_lev_idle: assert property (!rx_valid |=> $stable(q.lev))
      else $error("level words moved without sample");
   a_disc_on: assert property (s_quiet_sample ##1 q.lev[0] > q.dthr |-> q.flags[0])
      else $error("discrete bit low above threshold");
   a_disc_off: assert property (s_quiet_sample ##1 q.lev[5] < q.dthr |-> !q.flags[5])
      else $error("discrete bit high below threshold");
   a_eq_hold: assert property (!(v22_rx_active && err_valid) |=> $stable(q.eqavg))
      else $error("quality average moved while idle");
   a_apb_ready: assert property (psel && !penable |=> pready || !psel)
      else $error("access phase not completed at once");

endmodule : tone_detector_bank

// file: tone_detector_bank_tb.sv
// Self-checking bench for the tone detector bank, driven over APB and sample links.
// Assumes the package and design files are compiled first; slave answers with no wait.
`timescale 1ns/1ns
module testbench;
   import tone_detector_pkg::*;

   // ****************************************
   // Signals
   // ****************************************
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              rx_valid;
   logic [15:0]       rx_sample;
   logic              v22_rx_active;
   logic              err_valid;
   logic [15:0]       err_re;
   logic [15:0]       err_im;
   logic              eye_quality_error_flag;
   logic [31:0]       rd;
   logic              er;
   logic [15:0]       lv [16];
   logic [15:0]       fl;
   logic [15:0]       wv [16];
   int                error_cnt;
   int                n_checks;
   int                seed;

   tone_detector_bank u_dut (
      .pclk                   (pclk),
      .presetn                (presetn),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .rx_valid               (rx_valid),
      .rx_sample              (rx_sample),
      .v22_rx_active          (v22_rx_active),
      .err_valid              (err_valid),
      .err_re                 (err_re),
      .err_im                 (err_im),
      .eye_quality_error_flag (eye_quality_error_flag)
   );

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // One APB transfer; waits for pready, only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [8:0] idx, input logic [15:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {16'h0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [8:0] idx, input logic [15:0] exp);
      apb(1'b0, idx, 16'h0000);
      chk(rd, {16'h0000, exp});
   endtask : rd_chk

   // Samples spaced one idle cycle apart; noise stays within +/-2048
   task automatic samples(input int n, input logic loud);
      logic [31:0] r;
      repeat (n) begin
         r = $random(seed);
         @(posedge pclk);
         rx_valid  <= 1'b1;
         rx_sample <= loud ? {{4{r[11]}}, r[11:0]} : 16'h0000;
         @(posedge pclk);
         rx_valid  <= 1'b0;
      end
   endtask : samples

   task automatic errs(input int n, input logic [15:0] v);
      repeat (n) begin
         @(posedge pclk);
         err_valid <= 1'b1;
         err_re    <= v;
         err_im    <= v;
         @(posedge pclk);
         err_valid <= 1'b0;
      end
      // One idle edge so the flag has settled before anyone looks at it
      @(posedge pclk);
   endtask : errs

   task automatic read_bank;
      for (int i = 0; i < 16; i++) begin
         apb(1'b0, IDX_LEV + 9'(i), 16'h0000);
         lv[i] = rd[15:0];
      end
      apb(1'b0, IDX_FLAGS, 16'h0000);
      fl = rd[15:0];
   endtask : read_bank

   // Above sets, below clears, equal keeps the previous bit
   function automatic logic [15:0] exp_flags(input logic [15:0] thr, input logic [15:0] prev);
      logic [15:0] f;
      f = prev;
      for (int i = 0; i < 16; i++) begin
         if (lv[i] > thr) f[i] = 1'b1;
         else if (lv[i] < thr) f[i] = 1'b0;
      end
      return f;
   endfunction : exp_flags

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 32'hB1BB;
      error_cnt = 0;
      n_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
      rx_valid = 1'b0;
      rx_sample = 16'h0000;
      v22_rx_active = 1'b0;
      err_valid = 1'b0;
      err_re = 16'h0000;
      err_im = 16'h0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Reset contents and read-only protection
      rd_chk(IDX_FLAGS, PART_ID_DEF);
      for (int i = 0; i < 20; i++) rd_chk(IDX_BQA + 9'(i), BQ_DEF[i]);
      apb(1'b1, IDX_FLAGS, 16'hFFFF);
      rd_chk(IDX_FLAGS, PART_ID_DEF);
      // Unmapped word is refused on both directions
      apb(1'b1, 9'h1FF, 16'h1234);
      chk({31'h0, er}, 32'h1);
      rd_chk(9'h1FF, 16'h0000);
      chk({31'h0, er}, 32'h1);
      // Random coefficients, back-read
      for (int i = 0; i < 16; i++) begin
         wv[i] = 16'($random(seed));
         apb(1'b1, IDX_COEF + 9'(i), wv[i]);
      end
      for (int i = 0; i < 16; i++) rd_chk(IDX_COEF + 9'(i), wv[i]);
      apb(1'b1, IDX_BQB + 9'h009, wv[3]);
      rd_chk(IDX_BQB + 9'h009, wv[3]);
      apb(1'b1, IDX_BQB + 9'h009, BQ_DEF[19]);
      // Early threshold writes are lost on entering detect mode
      apb(1'b1, IDX_DTHR, 16'h1111);
      apb(1'b1, IDX_BON, 16'h2222);
      apb(1'b1, IDX_BOFF, 16'h3333);
      apb(1'b1, IDX_MODE, {9'h000, MODE_DETECT});
      rd_chk(IDX_DTHR, DTHR_DEF);
      rd_chk(IDX_BON, BON_DEF);
      rd_chk(IDX_BOFF, BOFF_DEF);
      // Zero thresholds: any energy switches detectors on
      apb(1'b1, IDX_DTHR, 16'h0000);
      apb(1'b1, IDX_BON, 16'h0000);
      apb(1'b1, IDX_BOFF, 16'h0000);
      apb(1'b0, IDX_FLAGS, 16'h0000);
      fl = rd[15:0];
      samples(200, 1'b1);
      apb(1'b0, IDX_TSTAT, 16'h0000);
      chk({30'h0, rd[15:14]}, 32'h3);
      begin
         logic [15:0] prev;
         prev = fl;
         read_bank;
         chk({16'h0000, fl}, {16'h0000, exp_flags(16'h0000, prev)});
         prev = fl;
         apb(1'b1, IDX_DTHR, 16'h0200);
         samples(20, 1'b1);
         read_bank;
         chk({16'h0000, fl}, {16'h0000, exp_flags(16'h0200, prev)});
      end
      // High off point clears band flags
      apb(1'b1, IDX_BON, 16'h7FFF);
      apb(1'b1, IDX_BOFF, 16'h7FFF);
      samples(50, 1'b1);
      apb(1'b0, IDX_TSTAT, 16'h0000);
      chk({30'h0, rd[15:14]}, 32'h0);
      // Chain and bypass bits are writable, flag bits are not
      apb(1'b1, IDX_TSTAT, 16'hFFFF);
      apb(1'b0, IDX_TSTAT, 16'h0000);
      chk(rd & 32'h0000_E020, 32'h0000_2020);
      // Chained and squared, the weak B output leaves A quiet; bypass lets it through
      apb(1'b1, IDX_BON, 16'h0000);
      apb(1'b1, IDX_BOFF, 16'h0001);
      apb(1'b1, IDX_TSTAT, 16'h2000);
      samples(300, 1'b1);
      apb(1'b0, IDX_TSTAT, 16'h0000);
      chk({31'h0, rd[TS_A_BIT]}, 32'h0);
      apb(1'b1, IDX_TSTAT, 16'h2020);
      samples(100, 1'b1);
      apb(1'b0, IDX_TSTAT, 16'h0000);
      chk({31'h0, rd[TS_A_BIT]}, 32'h1);
      apb(1'b1, IDX_TSTAT, 16'h0000);
      // Standby restores the identifier; samples then leave levels alone
      apb(1'b0, IDX_LEV, 16'h0000);
      lv[0] = rd[15:0];
      apb(1'b1, IDX_MODE, {9'h000, MODE_STANDBY});
      rd_chk(IDX_FLAGS, PART_ID_DEF);
      samples(10, 1'b1);
      rd_chk(IDX_LEV, lv[0]);
      // Eye quality monitor
      v22_rx_active <= 1'b1;
      errs(100, 16'h7FFF);
      chk({31'h0, eye_quality_error_flag}, 32'h1);
      apb(1'b0, IDX_MISC, 16'h0000);
      chk({31'h0, rd[EYE_BIT]}, 32'h1);
      // Average saturates below 0xFFFF, so a top limit is never exceeded
      apb(1'b1, IDX_EQLIM, 16'hFFFF);
      errs(1, 16'h7FFF);
      chk({31'h0, eye_quality_error_flag}, 32'h0);
      apb(1'b1, IDX_EQLIM, EQLIM_DEF);
      errs(300, 16'h0000);
      rd_chk(IDX_EQAVG, 16'h0000);
      chk({31'h0, eye_quality_error_flag}, 32'h0);
      v22_rx_active <= 1'b0;
      errs(20, 16'h7FFF);
      rd_chk(IDX_EQAVG, 16'h0000);
      wrap_up;
   end

   // Watchdog: the full sequence needs well under 10k cycles
   initial begin
      #400000;
      error_cnt++;
      wrap_up;
   end

endmodule : testbench
